// [rtl/sfo_switching_ctrl.sv]
// sfo_switching_ctrl: switching period, sync, shutdown and overcurrent sequencing
// assumes comparator/strap/ext clock pins are asynchronous; adc and duty inputs on pclk
`timescale 1ns/1ps

// restoring divider, free running, new quotient every W+1 cycles
module sfo_div #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] num,
    input  wire logic [W-1:0] den,
    output logic      [W-1:0] quot
);
    logic [W-1:0]         r_reg;      // partial remainder
    logic [W-1:0]         q_reg;      // dividend shifting into quotient
    logic [$clog2(W):0]   c_reg;      // step counter
    wire  [W:0]           sh = {r_reg, q_reg[W-1]};
    wire                  ge = sh >= {1'b0, den};
    wire  [W:0]           df = sh - {1'b0, den};

    // one quotient bit per clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
            q_reg <= '0;
            c_reg <= '0;
            quot  <= '0;
        end else if (c_reg == '0) begin
            r_reg <= '0;
            q_reg <= num;
            c_reg <= ($clog2(W)+1)'(W);
        end else begin
            r_reg <= ge ? df[W-1:0] : sh[W-1:0];
            q_reg <= {q_reg[W-2:0], ge};
            c_reg <= c_reg - 1'b1;
            if (c_reg == 1) begin
                quot <= {q_reg[W-2:0], ge};
            end
        end
    end
endmodule : sfo_div

module sfo_switching_ctrl #(
    parameter int HICCUP_CYCLES = sfo_pkg::HICCUP_CYC,
    parameter int EXT_TIMEOUT   = sfo_pkg::EXT_TO
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enable_above_thr,   // enable pin comparator
    input  wire logic        bus_address_strap_floating,
    input  wire logic        frequency_set_clock_pin,
    input  wire logic        oc_comp_trip,       // fast valley comparator
    input  wire logic        current_limit_select_float,
    input  wire logic        current_limit_select_high,
    input  wire logic [9:0]  rt_adc_code,        // adc reading of freq pin
    input  wire logic [15:0] iout_adc,           // avg current, 1/16 A
    input  wire logic        iout_valid,
    input  wire logic [7:0]  duty_cmd,           // loop duty, /256
    output logic             high_side_drv,
    output logic             low_side_drv,
    output logic             conv_enable,
    output logic             set_pulse,
    output logic             oc_sample,
    output logic [15:0]      ramp_slope,
    output logic [7:0]       oc_threshold,
    output logic             fault_alert_line_n,
    output logic             analog_mode
);
    localparam int PW = sfo_pkg::PW;

    if (HICCUP_CYCLES < 1 || EXT_TIMEOUT >= (1 << PW) || EXT_TIMEOUT <= 8) begin : g_chk
        $error("sfo_switching_ctrl: parameter out of range");
    end

    // pin synchronisers: en, strap, ext clock, oc, select float, select high
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= {current_limit_select_high, current_limit_select_float,
                       oc_comp_trip, frequency_set_clock_pin,
                       bus_address_strap_floating, enable_above_thr};
            s2_reg <= s1_reg;
        end
    end
    wire en_s  = s2_reg[0];
    wire strap_s = s2_reg[1];
    wire ext_s = s2_reg[2];
    wire oc_s  = s2_reg[3];

    // init sequence and one-shot captures
    logic [7:0] icnt_reg;
    logic       init_done_reg;
    logic       analog_reg;          // strap captured
    logic [3:0] rt_idx_reg;          // frequency index captured
    logic       locked_reg;          // ext clock present at init, analog mode only
    logic [1:0] ocsel_reg;           // {high, float} captured
    wire init_end = !init_done_reg && (icnt_reg == 8'(sfo_pkg::INIT_CYC - 1));

    // ext clock edge measurement
    logic          ext_prev_reg;
    logic [PW-1:0] ecnt_reg;         // cycles since last edge
    logic [PW-1:0] ext_per_reg;      // measured ext period
    logic          ext_seen_reg;     // clock currently present
    wire ext_rise = ext_s & ~ext_prev_reg;
    wire ext_lost = ecnt_reg == PW'(EXT_TIMEOUT);

    // registers
    logic [5:0]  ctrl_reg;
    logic [15:0] fsw_reg;
    logic [15:0] oclim_reg;
    logic [15:0] iout_reg;
    logic        warn_reg;
    logic        flt_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    // period machinery
    logic [PW-1:0] per_reg;
    logic [PW-1:0] pcnt_reg;
    logic [15:0]   div_q;
    logic [15:0]   slope_q;

    // overcurrent sequencer
    sfo_pkg::sfo_state_t state_reg;
    logic [1:0]  oc_run_reg;
    logic [1:0]  clr_run_reg;
    logic [1:0]  lvl_reg;            // 0 nominal, 3 = 0.125 cap
    logic [6:0]  oc_tot_reg;
    logic        oc_seen_reg;
    logic [$clog2(HICCUP_CYCLES+1)-1:0] hcnt_reg;

    // output flops
    logic hs_reg;
    logic ls_reg;
    logic set_reg;
    logic smp_reg;
    logic conv_reg;
    logic alert_n_reg;
    logic [7:0] thr_reg;

    // init counter and captures
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icnt_reg      <= '0;
            init_done_reg <= 1'b0;
            analog_reg    <= 1'b0;
            rt_idx_reg    <= '0;
            locked_reg    <= 1'b0;
            ocsel_reg     <= '0;
        end else if (!init_done_reg) begin
            icnt_reg <= icnt_reg + 1'b1;
            if (init_end) begin
                init_done_reg <= 1'b1;
                analog_reg    <= strap_s;
                rt_idx_reg    <= rt_adc_code[9:6];
                locked_reg    <= strap_s & ext_seen_reg;
                ocsel_reg     <= s2_reg[5:4];
            end
        end
    end

    // ext period measurement, presence needs two edges unless the first comes within EXT_TIMEOUT cycles of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_reg <= 1'b0;
            ecnt_reg     <= '0;
            ext_per_reg  <= sfo_pkg::DEF_PER;
            ext_seen_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_s;
            if (ext_rise) begin
                ext_per_reg  <= ecnt_reg + 1'b1;
                ecnt_reg     <= '0;
                ext_seen_reg <= !ext_lost;
            end else if (ext_lost) begin
                ext_seen_reg <= 1'b0;
            end else begin
                ecnt_reg <= ecnt_reg + 1'b1;
            end
        end
    end

    // free-running target: table in analog, register in digital
    wire [3:0]  rt_idx  = init_done_reg ? rt_idx_reg : rt_adc_code[9:6];
    wire [15:0] tgt_khz = (init_done_reg ? analog_reg : strap_s)
                          ? sfo_pkg::FREQ_TAB[rt_idx] : fsw_reg;
    wire [15:0] div_den = (tgt_khz == '0) ? 16'h0001 : tgt_khz;
    sfo_div #(.W(16)) u_per_div (
        .clk   (pclk),
        .rst_n (presetn),
        .num   (16'(sfo_pkg::CLK_KHZ)),
        .den   (div_den),
        .quot  (div_q)
    );
    wire [PW-1:0] free_per = (div_q > 16'((1 << PW) - 1)) ? '1 :
                             (div_q[PW-1:0] < sfo_pkg::MIN_PER) ? sfo_pkg::MIN_PER :
                             div_q[PW-1:0];
    wire [PW-1:0] ext_per  = (ext_per_reg < sfo_pkg::MIN_PER) ? sfo_pkg::MIN_PER : ext_per_reg;
    wire [PW-1:0] tgt_per  = ext_seen_reg ? ext_per : free_per;

    // ramp slope follows frequency so amplitude holds
    sfo_div #(.W(16)) u_slope_div (
        .clk   (pclk),
        .rst_n (presetn),
        .num   (sfo_pkg::RAMP_AMP),
        .den   ({{(16-PW){1'b0}}, per_reg}),
        .quot  (slope_q)
    );
    assign ramp_slope = slope_q;

    // cycle timing decode
    wire          sync_lock = ext_seen_reg && (per_reg == ext_per);
    wire          cyc_end   = pcnt_reg >= per_reg - 1'b1;
    wire          smp_win   = pcnt_reg < PW'(sfo_pkg::SAMPLE_CYC);
    // ext edge inside the valley window is ignored, no runt window
    wire          wrap      = cyc_end || (sync_lock && ext_rise && !smp_win);
    wire [PW-1:0] set_w     = per_reg >> 3;
    wire          set_w_on  = pcnt_reg < set_w;

    // period counter, target loaded at init end, then one step per wrap toward target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt_reg <= '0;
            per_reg  <= sfo_pkg::DEF_PER;
        end else begin
            pcnt_reg <= wrap ? '0 : pcnt_reg + 1'b1;
            if (init_end) begin
                per_reg <= tgt_per;
            end else if (init_done_reg && wrap && per_reg < tgt_per) begin
                per_reg <= per_reg + 1'b1;
            end else if (init_done_reg && wrap && per_reg > tgt_per) begin
                per_reg <= per_reg - 1'b1;
            end
        end
    end

    // duty cap and on-time
    wire [7:0] cap = (lvl_reg == 2'h1) ? sfo_pkg::CAP_HALF :
                     (lvl_reg == 2'h2) ? sfo_pkg::CAP_QTR : sfo_pkg::CAP_8TH;
    wire [7:0] duty_eff = (lvl_reg == 2'h0 || duty_cmd < cap) ? duty_cmd : cap;
    wire [PW+7:0] on_prod = duty_eff * per_reg;
    wire [PW:0]   on_end  = {1'b0, set_w} + {1'b0, on_prod[PW+7:8]};
    wire run_ok = (state_reg == sfo_pkg::S_RUN) && en_s &&
                  (analog_reg || !ctrl_reg[sfo_pkg::CTRL_OP_EN] ||
                   ctrl_reg[sfo_pkg::CTRL_OP_ON]);
    // switching starts only on a cycle boundary, stops at once
    logic live_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_reg <= 1'b0;
        end else begin
            live_reg <= run_ok && (live_reg || wrap);
        end
    end
    wire gate = run_ok && live_reg;
    wire hs_w = gate && !set_w_on && ({1'b0, pcnt_reg} < on_end);

    // overcurrent limit count, 8..64 or fixed 8 in analog
    wire [3:0] cnt_code = {1'b0, ctrl_reg[sfo_pkg::CTRL_CNT +: 3]} + 4'h1;
    wire [6:0] lim_max  = analog_reg ? sfo_pkg::LIM_STEP : {cnt_code, 3'h0};
    wire       lim_hit  = (oc_tot_reg + 1'b1) >= lim_max;
    wire       go_latch = !analog_reg && ctrl_reg[sfo_pkg::CTRL_LATCH];
    wire       sync_fail = locked_reg && !ext_seen_reg;

    // apb decode
    wire setup   = psel && !penable;
    wire wr_en   = psel && penable && pwrite && !analog_reg;
    wire wr_ctrl = wr_en && (paddr == sfo_pkg::A_CTRL);
    wire wr_freq = wr_en && (paddr == sfo_pkg::A_FREQ);
    wire wr_ocl  = wr_en && (paddr == sfo_pkg::A_OCLIM);
    wire wr_stat = wr_en && (paddr == sfo_pkg::A_STAT);
    wire clr_flt = wr_stat && pwdata[sfo_pkg::ST_FAULT];
    wire clr_wrn = wr_stat && pwdata[sfo_pkg::ST_WARN];
    wire warn_ev = iout_valid && (iout_adc > {4'h0, oclim_reg[15:8], 4'h0});
    wire trip_ev = (state_reg == sfo_pkg::S_RUN) && wrap && oc_seen_reg && lim_hit;

    // valley sample latch per cycle, comparator only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_seen_reg <= 1'b0;
        end else if (wrap) begin
            oc_seen_reg <= 1'b0;
        end else if (smp_win && oc_s && gate) begin
            oc_seen_reg <= 1'b1;
        end
    end

    // overcurrent sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= sfo_pkg::S_INIT;
            oc_run_reg  <= '0;
            clr_run_reg <= '0;
            lvl_reg     <= '0;
            oc_tot_reg  <= '0;
            hcnt_reg    <= '0;
        end else begin
            case (state_reg)
                sfo_pkg::S_INIT: begin
                    if (init_end) begin
                        state_reg <= sfo_pkg::S_RUN;
                    end
                end
                sfo_pkg::S_RUN: begin
                    if (sync_fail) begin
                        state_reg <= sfo_pkg::S_SYNCF;
                    end else if (wrap && oc_seen_reg) begin
                        clr_run_reg <= '0;
                        oc_tot_reg  <= oc_tot_reg + 1'b1;
                        oc_run_reg  <= (oc_run_reg == sfo_pkg::OC_RUN_STEP) ? '0
                                       : oc_run_reg + 1'b1;
                        if (oc_run_reg == sfo_pkg::OC_RUN_STEP && lvl_reg != 2'h3) begin
                            lvl_reg <= lvl_reg + 1'b1;
                        end
                        if (lim_hit) begin
                            hcnt_reg  <= '0;
                            state_reg <= go_latch ? sfo_pkg::S_LATCH : sfo_pkg::S_HIC;
                        end
                    end else if (wrap) begin
                        oc_run_reg <= '0;
                        if (lvl_reg == 2'h0) begin
                            oc_tot_reg  <= '0;
                            clr_run_reg <= '0;
                        end else if (clr_run_reg == sfo_pkg::CLR_RUN_STEP) begin
                            clr_run_reg <= '0;
                            lvl_reg     <= lvl_reg - 1'b1;
                        end else begin
                            clr_run_reg <= clr_run_reg + 1'b1;
                        end
                    end
                end
                sfo_pkg::S_HIC: begin
                    hcnt_reg <= hcnt_reg + 1'b1;
                    if (hcnt_reg == $bits(hcnt_reg)'(HICCUP_CYCLES - 1)) begin
                        state_reg   <= sfo_pkg::S_RUN;
                        oc_run_reg  <= '0;
                        clr_run_reg <= '0;
                        lvl_reg     <= '0;
                        oc_tot_reg  <= '0;
                    end
                end
                sfo_pkg::S_LATCH: begin
                    if (clr_flt) begin
                        state_reg   <= sfo_pkg::S_RUN;
                        oc_run_reg  <= '0;
                        clr_run_reg <= '0;
                        lvl_reg     <= '0;
                        oc_tot_reg  <= '0;
                    end
                end
                sfo_pkg::S_SYNCF: begin
                    state_reg <= sfo_pkg::S_SYNCF;            // only reset leaves
                end
                default: begin
                    state_reg <= sfo_pkg::S_INIT;
                end
            endcase
        end
    end

    // writable registers and sticky flags, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= sfo_pkg::CTRL_RST;
            fsw_reg   <= sfo_pkg::FSW_DEF_KHZ;
            oclim_reg <= sfo_pkg::OCLIM_RST;
            iout_reg  <= '0;
            warn_reg  <= 1'b0;
            flt_reg   <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_reg <= pwdata[5:0];
            if (wr_freq) fsw_reg <= pwdata[15:0];
            if (wr_ocl) oclim_reg <= pwdata[15:0];
            if (iout_valid) iout_reg <= iout_adc;
            warn_reg <= warn_ev | (warn_reg & ~clr_wrn);
            flt_reg  <= trip_ev | (flt_reg & ~clr_flt);
        end
    end

    // read mux, captured in setup so prdata is a flop
    wire [31:0] stat_w = {21'h0, state_reg, lvl_reg, conv_reg, flt_reg, warn_reg,
                          (state_reg == sfo_pkg::S_SYNCF), ext_seen_reg, analog_reg};
    wire        hit = (paddr == sfo_pkg::A_CTRL) || (paddr == sfo_pkg::A_FREQ) ||
                      (paddr == sfo_pkg::A_OCLIM) || (paddr == sfo_pkg::A_STAT) ||
                      (paddr == sfo_pkg::A_IOUT) || (paddr == sfo_pkg::A_PER);
    wire [31:0] rd_w = (paddr == sfo_pkg::A_CTRL)  ? {26'h0, ctrl_reg} :
                       (paddr == sfo_pkg::A_FREQ)  ? {16'h0, fsw_reg} :
                       (paddr == sfo_pkg::A_OCLIM) ? {16'h0, oclim_reg} :
                       (paddr == sfo_pkg::A_STAT)  ? stat_w :
                       (paddr == sfo_pkg::A_IOUT)  ? {16'h0, iout_reg} :
                       (paddr == sfo_pkg::A_PER)   ? {{(32-PW){1'b0}}, per_reg} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= rd_w;
            pslverr_reg <= !hit;
        end
    end
    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = pslverr_reg;

    // registered pin-side outputs
    wire [7:0] thr_w = !analog_reg ? oclim_reg[7:0] :
                       ocsel_reg[1] ? sfo_pkg::OCL_HIGH :
                       ocsel_reg[0] ? sfo_pkg::OCL_FLOAT : sfo_pkg::OCL_LOW;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_reg      <= 1'b0;
            ls_reg      <= 1'b0;
            set_reg     <= 1'b0;
            smp_reg     <= 1'b0;
            conv_reg    <= 1'b0;
            alert_n_reg <= 1'b1;
            thr_reg     <= '0;
        end else begin
            hs_reg      <= hs_w;
            ls_reg      <= gate && !hs_w;
            set_reg     <= gate && set_w_on;
            smp_reg     <= gate && smp_win;
            conv_reg    <= run_ok;
            alert_n_reg <= !(flt_reg || warn_reg || state_reg == sfo_pkg::S_SYNCF);
            thr_reg     <= thr_w;
        end
    end
    assign high_side_drv      = hs_reg;
    assign low_side_drv       = ls_reg;
    assign set_pulse          = set_reg;
    assign oc_sample          = smp_reg;
    assign conv_enable        = conv_reg;
    assign fault_alert_line_n = alert_n_reg;
    assign oc_threshold       = thr_reg;
    assign analog_mode        = analog_reg;
endmodule : sfo_switching_ctrl

// [rtl/sfo_pkg.sv]
// sfo_pkg: constants for the switching-frequency and overcurrent controller
// assumes a 40 MHz pclk and one APB slave with 32-bit data
package sfo_pkg;
    // clock and timing base
    localparam int CLK_KHZ   = 32'h9c40;          // 40000 kHz pclk
    localparam int CLK_NS    = 32'h19;            // 25 ns period
    localparam int SAMPLE_NS = 32'h4b;            // 75 ns valley sample
    localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HICCUP_MS = 32'h14;            // 20 ms hiccup hold
    localparam int HICCUP_CYC = HICCUP_MS * CLK_KHZ;
    localparam int INIT_CYC  = 32'h40;            // init sequence length
    localparam int PW        = 32'ha;             // period counter width
    localparam int EXT_TO    = 32'h200;           // no ext edge -> clock lost
    localparam logic [9:0]  MIN_PER  = 10'h008;   // shortest period allowed
    localparam logic [15:0] RAMP_AMP = 16'h1000;  // ramp amplitude, constant
    // analog-mode frequency table, kHz
    localparam logic [15:0] FREQ_TAB [16] = '{
        16'h0132, 16'h0164, 16'h0190, 16'h01bc, 16'h01f4, 16'h0226, 16'h0258, 16'h02c2,
        16'h02ee, 16'h0320, 16'h039b, 16'h03e8, 16'h0443, 16'h04b0, 16'h0535, 16'h05dc};
    localparam logic [15:0] FSW_DEF_KHZ = 16'h025f;   // 607 kHz digital default
    localparam logic [9:0]  DEF_PER = 10'(CLK_KHZ / FSW_DEF_KHZ);
    // duty caps, duty scaled to 256
    localparam logic [7:0] CAP_HALF = 8'h80;
    localparam logic [7:0] CAP_QTR  = 8'h40;
    localparam logic [7:0] CAP_8TH  = 8'h20;
    localparam logic [1:0] OC_RUN_STEP  = 2'h2;   // 3rd consecutive oc cycle
    localparam logic [1:0] CLR_RUN_STEP = 2'h3;   // 4th consecutive clear cycle
    localparam logic [6:0] LIM_STEP = 7'h08;      // limit count granularity
    // analog current-limit choices, amps
    localparam logic [7:0] OCL_FLOAT = 8'h0f;
    localparam logic [7:0] OCL_HIGH  = 8'h14;
    localparam logic [7:0] OCL_LOW   = 8'h0a;
    // register offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_FREQ  = 8'h04;
    localparam logic [7:0] A_OCLIM = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0c;
    localparam logic [7:0] A_IOUT  = 8'h10;
    localparam logic [7:0] A_PER   = 8'h14;
    // fields
    localparam int CTRL_OP_ON = 0;
    localparam int CTRL_OP_EN = 1;
    localparam int CTRL_LATCH = 2;
    localparam int CTRL_CNT   = 3;                // 3-bit limit count code
    localparam int OCL_WARN   = 8;                // warn limit at [15:8]
    localparam int ST_WARN    = 3;
    localparam int ST_FAULT   = 4;
    // reset values
    localparam logic [5:0]  CTRL_RST  = 6'h00;
    localparam logic [15:0] OCLIM_RST = 16'h1014; // warn 16 A, fault 20 A
    typedef enum logic [2:0] {
        S_INIT, S_RUN, S_HIC, S_LATCH, S_SYNCF
    } sfo_state_t;
endpackage : sfo_pkg

// [tb/sfo_switching_ctrl_asserts.sv]
// port checks for the switching controller
// bound into every sfo_switching_ctrl instance, pclk domain only
`timescale 1ns/1ps
module sfo_chk (
    input wire logic pclk, presetn, enable_above_thr, conv_enable, analog_mode,
    input wire logic high_side_drv, low_side_drv, set_pulse, oc_sample, fault_alert_line_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_en_off: assert property (!enable_above_thr [*3] |=>
        !high_side_drv && !low_side_drv) else $error("driver on, enable low");
    a_set_hs: assert property (set_pulse |-> !high_side_drv)
        else $error("high side on in set pulse");
    a_smp_start: assert property ($rose(set_pulse) |-> $rose(oc_sample))
        else $error("sample not at set pulse");
    a_smp_len: assert property ($rose(oc_sample) ##1 conv_enable [*2] |->
        oc_sample ##1 !oc_sample) else $error("sample window length");
    a_drv_gap: assert property (!(high_side_drv && low_side_drv))
        else $error("both drivers on");
    a_conv_drv: assert property (!conv_enable [*2] |-> !high_side_drv && !low_side_drv)
        else $error("driver on while stopped");
    a_hic_hold: assert property ($fell(conv_enable) && $fell(fault_alert_line_n) |->
        !conv_enable [*8]) else $error("stop too short");
    a_mode_fix: assert property (conv_enable |-> $stable(analog_mode))
        else $error("mode changed in run");
    // main scenarios reached
    cover property ($fell(conv_enable));
    cover property ($rose(high_side_drv));
    cover property ($rose(oc_sample) && set_pulse);
endmodule : sfo_chk
bind sfo_switching_ctrl sfo_chk i_chk (.pclk, .presetn, .enable_above_thr, .conv_enable,
    .analog_mode, .high_side_drv, .low_side_drv, .set_pulse, .oc_sample, .fault_alert_line_n);

// [tb/sfo_sync_src.sv]
// external sync clock source for the frequency pin
// assumes the bench raises run only while a clock should be applied
`timescale 1ns/1ps
module sfo_sync_src #(parameter int HALF_NS = 400) (
    input  wire logic run,   // clock applied while high
    output logic      clk_o  // stands still low when removed
);
    // gated free-running source, idle low between uses
    initial begin
        clk_o = 1'b0;
        forever #(HALF_NS) clk_o = run ? ~clk_o : 1'b0;
    end
endmodule : sfo_sync_src

// [tb/sfo_switching_ctrl_tb.sv]
// apb-driven bench for the switching controller
// assumes sfo_pkg, the controller and the sync source are compiled first
`timescale 1ns/1ps
module sfo_switching_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, en, oc, ext, xclk, ival, er, hs, ls;
    logic        pready, pslverr, conv, strap, al;
    logic [7:0]  paddr, duty, thr;
    logic [9:0]  rt;
    logic [15:0] iout;
    logic [31:0] pwdata, prdata, rd;
    int          fails = 0, checked = 0, n;
    sfo_switching_ctrl #(.HICCUP_CYCLES(200)) i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_above_thr(en),
        .bus_address_strap_floating(strap), .frequency_set_clock_pin(xclk), .oc_comp_trip(oc),
        .current_limit_select_float(1'b1), .current_limit_select_high(1'b0),
        .rt_adc_code(rt), .iout_adc(iout), .iout_valid(ival), .duty_cmd(duty),
        .high_side_drv(hs), .low_side_drv(ls), .conv_enable(conv), .set_pulse(),
        .oc_sample(), .ramp_slope(), .oc_threshold(thr), .fault_alert_line_n(al), .analog_mode());
    sfo_sync_src #(.HALF_NS(400)) i_src (.run(ext), .clk_o(xclk));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin fails++; $display("BAD %0t %s", $time, m); end
    endtask : chk
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; n = 0;
        @(posedge pclk) penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin fails++; end_of_test(); end
        rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // bounded wait for conv_enable, cycle count left in n
    task automatic wconv(input logic v, input int lim);
        n = 0;
        while (conv !== v && n < lim) begin @(posedge pclk); n++; end
        if (n >= lim) begin fails++; end_of_test(); end
    endtask : wconv
    task automatic t_basic;
        apb(0, sfo_pkg::A_FREQ, 0); chk(rd, 32'h25f, "freq default");
        apb(0, 8'h18, 0); chk({31'h0, er}, 32'h1, "unmapped");
        iout <= 16'h0123; ival <= 1'b1; @(posedge pclk) ival <= 1'b0;
        repeat (70) @(posedge pclk);
        apb(0, sfo_pkg::A_PER, 0); chk(rd, 32'h41, "default period");
        apb(0, sfo_pkg::A_IOUT, 0); chk(rd, 32'h123, "current");
        chk({31'h0, al}, 32'h0, "warn alert");
        apb(1, sfo_pkg::A_STAT, 32'h8); apb(1, sfo_pkg::A_OCLIM, 32'h2010);
        apb(1, sfo_pkg::A_FREQ, 32'h5ae);
        repeat (200) @(posedge pclk);
        apb(0, sfo_pkg::A_PER, 0); chk({31'h0, rd > 32'h1b && rd < 32'h41}, 32'h1, "step");
        chk({23'h0, al, thr}, 32'h110, "limit, alert clear");
        repeat (3000) @(posedge pclk);
        apb(0, sfo_pkg::A_PER, 0); chk(rd, 32'h1b, "new period");
        $display("frequency test done");
    endtask : t_basic
    task automatic t_oc;
        oc <= 1'b1; wconv(0, 2000);
        apb(0, sfo_pkg::A_STAT, 0); chk({29'h0, rd[10:8]}, 32'h2, "hiccup state");
        wconv(1, 400); chk({31'h0, n > 185 && n < 215}, 32'h1, "hiccup length");
        wconv(0, 2000); oc <= 1'b0; wconv(1, 400);
        apb(1, sfo_pkg::A_STAT, 32'h10); apb(0, sfo_pkg::A_STAT, 0);
        chk({31'h0, rd[4]}, 32'h0, "fault cleared");
        $display("overcurrent test done");
    endtask : t_oc
    task automatic t_shut;
        en <= 1'b0; repeat (5) @(posedge pclk);
        chk({30'h0, hs, ls}, 32'h0, "drivers off");
        en <= 1'b1; wconv(1, 200);
        apb(1, sfo_pkg::A_CTRL, 32'h2); wconv(0, 50);
        apb(1, sfo_pkg::A_CTRL, 32'h3); wconv(1, 200);
        $display("shutdown test done");
    endtask : t_shut
    task automatic t_sync;
        ext <= 1'b1; repeat (1500) @(posedge pclk);
        apb(0, sfo_pkg::A_STAT, 0); chk({31'h0, rd[1]}, 32'h1, "ext present");
        apb(0, sfo_pkg::A_PER, 0); chk(rd, 32'h20, "ext period");
        ext <= 1'b0; repeat (1500) @(posedge pclk);
        apb(0, sfo_pkg::A_STAT, 0); chk({30'h0, rd[2:1]}, 32'h0, "ext gone");
        apb(0, sfo_pkg::A_PER, 0); chk(rd, 32'h1b, "free period");
        $display("sync test done");
    endtask : t_sync
    // second reset into analog mode, table index 15, float select pin
    task automatic t_ana;
        strap <= 1'b1; rt <= 10'h3c0; presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1; repeat (80) @(posedge pclk);
        rt <= 10'h000; repeat (300) @(posedge pclk);
        apb(0, sfo_pkg::A_PER, 0); chk(rd, 32'h1a, "table period");
        apb(1, sfo_pkg::A_FREQ, 32'h100); apb(0, sfo_pkg::A_FREQ, 0);
        chk(rd, 32'h25f, "write ignored");
        apb(0, sfo_pkg::A_STAT, 0); chk({23'h0, rd[0], thr}, 32'h10f, "analog limit");
        $display("analog test done");
    endtask : t_ana
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; en = 1'b1; oc = 1'b0; ext = 1'b0; ival = 1'b0; iout = 16'h0;
        duty = 8'h60; strap = 1'b0; rt = 10'h000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_basic(); t_oc(); t_shut(); t_sync(); t_ana();
        end_of_test();
    end
endmodule : sfo_switching_ctrl_tb
